// ### dv/scs_ext_clk_model.sv
`timescale 1ns/1ps
`default_nettype none
module scs_ext_clk_model #(
  parameter int HALF = 3
) (
  input wire logic i_core_clk,
  input wire logic i_run,
  output logic o_level
);
  int cnt;
  initial begin
    o_level = 1'b0;
    cnt = 0;
  end
  // square logic clock
  // free running; i_run low stops it with the level frozen
  always @(posedge i_core_clk) begin
    if (i_run) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        o_level <= ~o_level;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/system_clock_source_select_test.sv
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_select_test;
  import scs_pkg::*;
  logic clk, srst, awvalid, wvalid, bready, arvalid, rready, en_n, ext_run, sec_run, fast_seen;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, d, tv;
  logic [1:0] mode, r;
  wire logic awready, wready, bvalid, arready, rvalid, sys_clk, st_en, gpio, co_o, co_oe, fast;
  wire logic [1:0] bresp, rresp, src;
  wire logic [31:0] rdata;
  wire logic ext_lvl, sec_lvl;
  int err_total, samples_checked, seed, n, m;

  scs_clock_ctrl #(.HF_READY_C(3), .HF_LOCK_C(5), .HF_STABLE_C(8), .MF_READY_C(2)) i_dut (
    .i_core_clk(clk), .i_srst(srst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_power_up_clock_mode(mode),
    .i_clock_out_pin_enable_n(en_n), .i_clock_input_pin(ext_lvl), .i_secondary_osc(sec_lvl),
    .o_sys_clk(sys_clk), .o_startup_timer_en(st_en), .o_clock_input_pin_is_gpio(gpio),
    .o_clock_output_pin_o(co_o), .o_clock_output_pin_oe(co_oe), .o_fast_startup_active(fast),
    .o_active_source(src));
  scs_ext_clk_model i_ext (.i_core_clk(clk), .i_run(ext_run), .o_level(ext_lvl));
  scs_ext_clk_model #(.HALF(5)) i_sec (.i_core_clk(clk), .i_run(sec_run), .o_level(sec_lvl));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] ctrl_word(input logic [1:0] s, input logic [3:0] f);
    return {25'h0, f, 1'b0, s};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
    int k;
    logic done;
    k = 0;
    done = 1'b0;
    awaddr <= a; wdata <= v; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!done && k < 100) begin
      @(posedge clk);
      k++;
      if (bvalid === 1'b1) begin done = 1'b1; resp = bresp; end
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end
    if (!done) begin err_total++; $display("wrong value at %0t: write hang", $time); end
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    int k;
    logic done;
    k = 0;
    done = 1'b0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!done && k < 100) begin
      @(posedge clk);
      k++;
      if (rvalid === 1'b1) begin done = 1'b1; v = rdata; resp = rresp; end
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end
    if (!done) begin err_total++; $display("wrong value at %0t: read hang", $time); end
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic do_reset(input logic [1:0] md, input logic e, input int cyc);
    srst <= 1'b1; mode <= md; en_n <= e;
    repeat (cyc) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_src(input logic [1:0] s);
    int k;
    k = 0;
    while (src !== s && k < 400) begin @(posedge clk); k++; end
    chk({30'h0, src}, {30'h0, s}, "active source");
  endtask
  task automatic count_toggles(output int c);
    logic last;
    c = 0;
    last = sys_clk;
    repeat (40) begin
      @(posedge clk);
      if (sys_clk !== last) c++;
      last = sys_clk;
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ****************************************
  // clock, watchdog, monitor
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    summarize();
  end
  always @(posedge clk) if (fast === 1'b1) fast_seen <= 1'b1;

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    seed = 42; err_total = 0; samples_checked = 0; fast_seen = 1'b0; ext_run = 1'b1; sec_run = 1'b1;
    srst = 1'b1; mode = 2'h0; en_n = 1'b1; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; wstrb = 4'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    for (m = 0; m < 4; m++) begin
      do_reset(m[1:0], 1'($random(seed)), (m == 0) ? 20 : 2);
      mode <= ~m[1:0];
      rd(OFF_CONFIG, d, r);
      chk(d, {29'h0, en_n, m[1:0]}, "captured config");
      chk({31'h0, co_oe}, {31'h0, ~en_n}, "clock out enable");
      chk({31'h0, st_en}, {31'h0, m == 0}, "startup timer");
      chk({31'h0, gpio}, {31'h0, m == 0}, "clock input gpio");
      rd(OFF_CTRL, d, r);
      chk(d, ctrl_word(2'h0, 4'h7), "ctrl reset");
      wait_src((m == 0) ? 2'h2 : 2'h0);
    end
    count_toggles(n);
    chk({31'h0, n > 0}, 32'h1, "ext clock runs");
    ext_run <= 1'b0;
    repeat (4) @(posedge clk);
    count_toggles(n);
    chk(n, 32'h0, "halted clock");
    ext_run <= 1'b1;
    count_toggles(n);
    chk({31'h0, n > 0}, 32'h1, "clock resumes");
    chk({31'h0, co_o}, {31'h0, sys_clk}, "clock out level");
    wr(OFF_CTRL, ctrl_word(2'h2, 4'h7), r);
    wait_src(2'h2);
    repeat (10) @(posedge clk);
    rd(OFF_STATUS, d, r);
    chk({30'h0, d[6:5]}, 32'h2, "status source");
    chk({31'h0, d[3]}, 32'h1, "medium ready");
    fast_seen = 1'b0;
    wr(OFF_CTRL, ctrl_word(2'h3, 4'hF), r);
    repeat (40) @(posedge clk);
    rd(OFF_STATUS, d, r);
    chk({29'h0, d[2:0]}, 32'h7, "high ready locked stable");
    chk({31'h0, d[7]}, 32'h0, "fast startup off");
    chk({31'h0, fast_seen}, 32'h1, "fast startup seen");
    wr(OFF_CTRL, ctrl_word(2'h2, 4'h0), r);
    repeat (40) @(posedge clk);
    rd(OFF_STATUS, d, r);
    chk({31'h0, d[4]}, 32'h1, "low ready");
    for (m = 1; m < 16; m++) begin
      wr(OFF_CTRL, ctrl_word(2'h2 | m[0], m[3:0]), r);
      rd(OFF_CTRL, d, r);
      chk(d, ctrl_word(2'h2 | m[0], m[3:0]), "freq select");
      wait_src(2'h2);
    end
    repeat (8) begin
      tv = $random(seed);
      wr(OFF_TRIM, tv, r);
      rd(OFF_TRIM, d, r);
      chk(d, {26'h0, tv[5:0]}, "trim");
    end
    wr(OFF_CTRL, ctrl_word(2'h1, 4'h7), r);
    wait_src(2'h1);
    wr(OFF_CTRL, ctrl_word(2'h0, 4'h7), r);
    wait_src(2'h0);
    wr(OFF_CONFIG, 32'hFF, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "ro write resp");
    rd(OFF_CONFIG, d, r);
    chk(d, {29'h0, en_n, 2'h3}, "config unchanged");
    wr(4'h1, 32'hFF, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    rd(4'h1, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(OFF_CTRL, ctrl_word(2'h3, 4'hF), r);
    repeat (5) @(posedge clk);
    do_reset(2'h2, 1'b0, 2);
    rd(OFF_CTRL, d, r);
    chk(d, ctrl_word(2'h0, 4'h7), "ctrl after reset");
    summarize();
  end
endmodule
`default_nettype wire

// ### hw/scs_clock_ctrl.sv
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - power-up clock mode is taken from the two-bit configuration field
// - mode 11 high, 10 medium, 01 low external; 00 internal oscillator
// - external modes bypass the start-up timer, no added delay
// - fully static core: stopped external clock halts, resumes with state kept
// - run-time clock select field overrides the power-up selection
// - select 00 default, 01 secondary oscillator, 1x internal; cleared on reset
// - internal mode releases the clock input pin for general I/O
// - clock output pin is I/O or clock output per enable bit
// - enable bit active low: 0 drives clock out, 1 disables it
// - high source is the medium source multiplied by a PLL
// - separate uncalibrated low source, not tied to medium source
// - high source passes a postscaler and mux steered by frequency select
// - frequency select offers seven postscaled medium and eight postscaled high frequencies
// - frequency select loads 0111 on any reset
// - high source enabled when selected and mode 00 or select 1x
// - medium source enabled when selected and mode 00 or select 1x
// - fast start-up oscillator runs until the high source is stable
// - status holds a read-only high source ready flag
// - high locked flag set within two percent of final frequency
// - high stable flag set within half percent of final frequency
// - status holds a medium source ready flag
// - trim register shifts medium source and thus the high source
module scs_clock_ctrl
  import scs_pkg::*;
#(
  parameter int HF_READY_C = HF_READY_CYC,
  parameter int HF_LOCK_C = HF_LOCK_CYC,
  parameter int HF_STABLE_C = HF_STABLE_CYC,
  parameter int MF_READY_C = MF_READY_CYC,
  parameter int LF_READY_C = LF_READY_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [AXI_AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [AXI_AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [1:0] i_power_up_clock_mode,
  input wire logic i_clock_out_pin_enable_n,
  input wire logic i_clock_input_pin,
  input wire logic i_secondary_osc,
  output logic o_sys_clk,
  output logic o_startup_timer_en,
  output logic o_clock_input_pin_is_gpio,
  output logic o_clock_output_pin_o,
  output logic o_clock_output_pin_oe,
  output logic o_fast_startup_active,
  output logic [1:0] o_active_source
);
  // ****************************************
  // configuration capture
  // ****************************************
  logic [1:0] pu_mode_q;
  logic clock_output_pin_en_n_q;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pu_mode_q <= i_power_up_clock_mode;
      clock_output_pin_en_n_q <= i_clock_out_pin_enable_n;
    end
  end
  wire pu_internal = (pu_mode_q == MODE_INTERNAL);

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [1:0] run_sel_q;
  logic [3:0] freq_sel_q;
  logic [5:0] trim_q;
  logic [4:0] sts_sync1_q, sts_sync2_q;
  scs_src_t cur_src_q;
  assign o_awready = !aw_held_q && !bvalid_q;
  assign o_wready = !w_held_q && !bvalid_q;
  assign o_arready = !rvalid_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  wire aw_take = i_awvalid && o_awready;
  wire w_take = i_wvalid && o_wready;
  wire ar_take = i_arvalid && o_arready;
  wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
  wire wr_ctrl = wr_fire && (awaddr_q == OFF_CTRL) && wstrb_q[0];
  wire wr_trim = wr_fire && (awaddr_q == OFF_TRIM) && wstrb_q[0];
  wire wr_ok = (awaddr_q == OFF_CTRL) || (awaddr_q == OFF_TRIM) ||
               (awaddr_q == OFF_STATUS) || (awaddr_q == OFF_CONFIG);
  wire rd_ok = (i_araddr == OFF_CTRL) || (i_araddr == OFF_TRIM) ||
               (i_araddr == OFF_STATUS) || (i_araddr == OFF_CONFIG);
  wire [31:0] ctrl_view = 32'({freq_sel_q, 1'b0, run_sel_q});
  wire [31:0] sts_view = 32'({o_fast_startup_active, cur_src_q, sts_sync2_q});
  wire [31:0] trim_view = 32'(trim_q);
  wire [31:0] cfg_view = 32'({clock_output_pin_en_n_q, pu_mode_q});
  wire [31:0] rd_mux = (i_araddr == OFF_CTRL) ? ctrl_view :
                       (i_araddr == OFF_STATUS) ? sts_view :
                       (i_araddr == OFF_TRIM) ? trim_view :
                       (i_araddr == OFF_CONFIG) ? cfg_view : 32'h00000000;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q <= i_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && i_bready) begin
        bvalid_q <= 1'b0;
      end
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && i_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // control and trim registers
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      run_sel_q <= RUN_SEL_RST;
      freq_sel_q <= FREQ_SEL_RST;
      trim_q <= TRIM_RST;
    end else begin
      if (wr_ctrl) begin
        run_sel_q <= wdata_q[CTRL_SEL_LSB +: 2];
        freq_sel_q <= wdata_q[CTRL_FREQ_LSB +: 4];
      end
      if (wr_trim) begin
        trim_q <= wdata_q[5:0];
      end
    end
  end

  // ****************************************
  // oscillator enables
  // ****************************************
  wire int_path = pu_internal || run_sel_q[1];
  wire sel_low = (freq_sel_q == FREQ_LOW_CODE);
  // top bit picks the high-source postscaler
  wire sel_high = freq_sel_q[3];
  wire sel_med = !sel_low && !sel_high;
  wire hf_en = sel_high && int_path;
  wire mf_en = sel_med && int_path;
  wire mf_run = mf_en || hf_en;
  wire lf_en = sel_low && int_path;

  // ****************************************
  // start-up counters per oscillator
  // ****************************************
  localparam int NOSC = 3;
  wire [NOSC-1:0] osc_en = {lf_en, mf_run, hf_en};
  localparam int OSC_LIM [NOSC] = '{HF_STABLE_C, MF_READY_C, LF_READY_C};
  logic [CNT_W-1:0] osc_cnt_q [NOSC];
  genvar g;
  generate
    for (g = 0; g < NOSC; g++) begin : g_osc
      always_ff @(posedge i_core_clk) begin
        if (i_srst || !osc_en[g]) begin
          osc_cnt_q[g] <= '0;
        end else if (osc_cnt_q[g] < CNT_W'(OSC_LIM[g])) begin
          osc_cnt_q[g] <= osc_cnt_q[g] + CNT_W'(1);
        end
      end
    end
  endgenerate
  wire hf_rdy_raw = hf_en && (osc_cnt_q[0] >= CNT_W'(HF_READY_C));
  wire hf_lock_raw = hf_en && (osc_cnt_q[0] >= CNT_W'(HF_LOCK_C));
  wire hf_stab_raw = hf_en && (osc_cnt_q[0] >= CNT_W'(HF_STABLE_C));
  wire mf_rdy_raw = mf_run && (osc_cnt_q[1] >= CNT_W'(MF_READY_C));
  wire lf_rdy_raw = lf_en && (osc_cnt_q[2] >= CNT_W'(LF_READY_C));
  wire [4:0] sts_raw = {lf_rdy_raw, mf_rdy_raw, hf_stab_raw, hf_lock_raw, hf_rdy_raw};
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sts_sync1_q <= '0;
      sts_sync2_q <= '0;
    end else begin
      sts_sync1_q <= sts_raw;
      sts_sync2_q <= sts_sync1_q;
    end
  end
  assign o_fast_startup_active = hf_en && !sts_sync2_q[2];

  // ****************************************
  // internal source phase model
  // ****************************************
  logic [ACC_W-1:0] mf_acc_q, hf_acc_q;
  logic [CNT_W-1:0] lf_cnt_q;
  wire [ACC_W-1:0] mf_step = MF_STEP + {{(ACC_W-6){trim_q[5]}}, trim_q};
  wire [ACC_W-1:0] hf_step = mf_step << PLL_SHIFT;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      mf_acc_q <= '0;
      hf_acc_q <= '0;
      lf_cnt_q <= '0;
    end else begin
      if (mf_run) begin
        mf_acc_q <= mf_acc_q + mf_step;
      end
      if (hf_en) begin
        hf_acc_q <= hf_acc_q + hf_step;
      end
      if (lf_en) begin
        lf_cnt_q <= lf_cnt_q + CNT_W'(1);
      end
    end
  end
  wire [4:0] mf_tap = 5'(MF_POST_BASE) + 5'(FREQ_MED_TOP - freq_sel_q);
  wire [4:0] hf_tap = 5'(HF_POST_BASE) + 5'(FREQ_HIGH_TOP - freq_sel_q);
  wire int_level = sel_low ? lf_cnt_q[LF_BIT] :
                   sel_high ? hf_acc_q[hf_tap] : mf_acc_q[mf_tap];
  wire int_ready = sel_low ? lf_rdy_raw : sel_high ? hf_stab_raw : mf_rdy_raw;

  // ****************************************
  // glitch-free source switch
  // ****************************************
  scs_state_t state_q;
  scs_src_t tgt_src_q;
  logic [3:0] cur_freq_q;
  logic sys_clk_q;
  // select decode, 1x wins over default
  wire scs_src_t req_src = run_sel_q[1] ? SCS_SRC_INT :
                           (run_sel_q == SEL_SECONDARY) ? SCS_SRC_SEC :
                           pu_internal ? SCS_SRC_INT : SCS_SRC_EXT;
  // external sources need no start-up wait
  wire req_ready = (req_src == SCS_SRC_INT) ? int_ready : 1'b1;
  wire req_change = (req_src != cur_src_q) ||
                    ((req_src == SCS_SRC_INT) && (freq_sel_q != cur_freq_q));
  // external clock sampled as-is, no watchdog on it
  wire cur_level = (cur_src_q == SCS_SRC_EXT) ? i_clock_input_pin :
                   (cur_src_q == SCS_SRC_SEC) ? i_secondary_osc : int_level;
  wire tgt_level = (tgt_src_q == SCS_SRC_EXT) ? i_clock_input_pin :
                   (tgt_src_q == SCS_SRC_SEC) ? i_secondary_osc : int_level;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_q <= SCS_ST_RUN;
      cur_src_q <= SCS_SRC_EXT;
      tgt_src_q <= SCS_SRC_EXT;
      cur_freq_q <= FREQ_SEL_RST;
      sys_clk_q <= 1'b0;
    end else begin
      case (state_q)
        // wait for target ready, then old low
        SCS_ST_RUN: begin
          sys_clk_q <= cur_level;
          if (req_change && req_ready) begin
            tgt_src_q <= req_src;
            state_q <= SCS_ST_WAIT_LOW;
          end
        end
        SCS_ST_WAIT_LOW: begin
          sys_clk_q <= cur_level;
          if (!cur_level) begin
            state_q <= SCS_ST_WAIT_HIGH;
          end
        end
        // hold low until new source rises
        SCS_ST_WAIT_HIGH: begin
          sys_clk_q <= 1'b0;
          if (tgt_level) begin
            cur_src_q <= tgt_src_q;
            cur_freq_q <= freq_sel_q;
            state_q <= SCS_ST_RUN;
          end
        end
        default: begin
          state_q <= SCS_ST_RUN;
          sys_clk_q <= 1'b0;
        end
      endcase
    end
  end
  assign o_sys_clk = sys_clk_q;
  assign o_active_source = cur_src_q;

  // ****************************************
  // pins and start-up timer
  // ****************************************
  // bypass start-up timer in external modes
  assign o_startup_timer_en = pu_internal;
  assign o_clock_input_pin_is_gpio = pu_internal;
  assign o_clock_output_pin_oe = !clock_output_pin_en_n_q;
  assign o_clock_output_pin_o = sys_clk_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  sequence s_enter_hold;
    (state_q == SCS_ST_WAIT_LOW) && !cur_level ##1 (state_q == SCS_ST_WAIT_HIGH);
  endsequence
  a_freq_reset_load: assert property (disable iff (1'b0) i_srst |=> freq_sel_q == 4'h7)
    else $error("frequency select not 0111 after reset");
  a_sel_reset_clear: assert property (disable iff (1'b0) i_srst |=> run_sel_q == 2'h0)
    else $error("clock select not cleared after reset");
  a_ext_no_timer: assert property (pu_mode_q != 2'h0 |-> !o_startup_timer_en && !o_clock_input_pin_is_gpio)
    else $error("start-up timer active in external mode");
  a_int_pin_free: assert property (pu_mode_q == 2'h0 |-> o_clock_input_pin_is_gpio)
    else $error("clock input pin not released in internal mode");
  a_clock_output_pin_drive: assert property (!clock_output_pin_en_n_q |-> o_clock_output_pin_oe && o_clock_output_pin_o == o_sys_clk)
    else $error("clock output not driven while enabled");
  a_hf_needs_mf: assert property (hf_en |-> mf_run)
    else $error("high source running without medium source");
  a_stable_order: assert property (sts_sync2_q[2] |-> sts_sync2_q[1] && sts_sync2_q[0])
    else $error("stable flag without locked and ready");
  a_ready_wait: assert property ($rose(hf_en) |-> !hf_rdy_raw [*3])
    else $error("high ready set too early");
  a_status_sync: assert property (hf_rdy_raw [*3] |-> sts_sync2_q[0])
    else $error("ready flag not synchronised in two cycles");
  a_switch_hold: assert property (s_enter_hold |-> !o_sys_clk)
    else $error("system clock not held low during switch");
  a_fast_until_stable: assert property ($rose(hf_en) |-> o_fast_startup_active [*3])
    else $error("fast start-up oscillator not active");
endmodule
`default_nettype wire

// ### hw/scs_pkg.sv
package scs_pkg;
  // ****************************************
  // bus and register map
  // ****************************************
  localparam int AXI_AW = 4;
  localparam logic [AXI_AW-1:0] OFF_CTRL = 4'h0;
  localparam logic [AXI_AW-1:0] OFF_STATUS = 4'h4;
  localparam logic [AXI_AW-1:0] OFF_TRIM = 4'h8;
  localparam logic [AXI_AW-1:0] OFF_CONFIG = 4'hC;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_FREQ_LSB = 3;
  localparam logic [1:0] RUN_SEL_RST = 2'h0;
  localparam logic [3:0] FREQ_SEL_RST = 4'h7;
  localparam logic [5:0] TRIM_RST = 6'h00;

  // ****************************************
  // status register fields
  // ****************************************
  localparam int STS_SRC_LSB = 5;
  localparam int STS_FAST_BIT = 7;

  // ****************************************
  // encodings
  // ****************************************
  localparam logic [1:0] MODE_EXT_HIGH = 2'h3;
  localparam logic [1:0] MODE_EXT_MED = 2'h2;
  localparam logic [1:0] MODE_EXT_LOW = 2'h1;
  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] SEL_DEFAULT = 2'h0;
  localparam logic [1:0] SEL_SECONDARY = 2'h1;
  localparam logic [3:0] FREQ_LOW_CODE = 4'h0;
  localparam logic [3:0] FREQ_HIGH_TOP = 4'hF;
  localparam logic [3:0] FREQ_MED_TOP = 4'h7;

  typedef enum logic [1:0] {
    SCS_SRC_EXT = 2'h0,
    SCS_SRC_SEC = 2'h1,
    SCS_SRC_INT = 2'h2
  } scs_src_t;

  typedef enum logic [2:0] {
    SCS_ST_RUN = 3'h1,
    SCS_ST_WAIT_LOW = 3'h2,
    SCS_ST_WAIT_HIGH = 3'h4
  } scs_state_t;

  // ****************************************
  // oscillator model
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int HF_READY_NS = 5000;
  localparam int HF_LOCK_NS = 20000;
  localparam int HF_STABLE_NS = 50000;
  localparam int MF_READY_NS = 2000;
  localparam int LF_READY_NS = 3000;
  localparam int HF_READY_CYC = (HF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HF_LOCK_CYC = (HF_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HF_STABLE_CYC = (HF_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MF_READY_CYC = (MF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LF_READY_CYC = (LF_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 10;
  localparam int ACC_W = 24;
  localparam logic [ACC_W-1:0] MF_STEP = 24'h000400;
  localparam int PLL_SHIFT = 5;
  localparam int MF_POST_BASE = 15;
  localparam int HF_POST_BASE = 15;
  localparam int LF_BIT = 8;
endpackage
